/* logic/hoist_bypass_contactor_ctrl.sv */
// By-pass contactor, extra brake and rotor step supervisor for a crane motion controller.
`timescale 1ns/1ps
`default_nettype none
module hoist_bypass_contactor_ctrl #(
    parameter logic [23:0] SEC_CYCLES_P = 24'(bypass_pkg::SEC_CYCLES),
    parameter logic [19:0] ASSIST_CYCLES_P = 20'(bypass_pkg::ASSIST_CYCLES)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [bypass_pkg::ADDR_W-1:0] addr,
    input wire logic [bypass_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [bypass_pkg::DATA_W-1:0] rdata,
    // Drive state and measurements
    input wire logic run_a,
    input wire logic run_b,
    input wire logic full_conduction,
    input wire logic speed_zero,
    input wire logic [6:0] load_pct,
    input wire logic [7:0] stack_temp,
    input wire logic [8:0] motor_current_pct,
    input wire logic signed [7:0] speed_pct,
    // Remote I/O outputs
    output logic raise_bypass_contactor,
    output logic lower_bypass_contactor,
    output logic brake1_release,
    output logic brake2_release,
    // Rotor steps and thyristor control
    output logic first_rotor_step_contactor,
    output logic second_rotor_step_contactor,
    output logic final_rotor_step_contactor,
    output logic thyristor_enable,
    output logic current_limit_active
);
    import bypass_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        bp_state_e st;
        logic [1:0] mode;
        logic [6:0] load_thr;
        logic [7:0] temp_lim;
        logic [9:0] hot_slot;
        logic [8:0] cur_lim;
        logic [6:0] lev1;
        logic [6:0] lev2;
        logic signed [7:0] step1;
        logic signed [7:0] step2;
        logic signed [7:0] step3;
        logic [5:0] fin_time;
        logic fin_trip;
        logic [23:0] sec_cnt;
        logic tick;
        logic [19:0] assist;
        logic raise;
        logic lower;
        logic b1;
        logic b2;
        logic k1;
        logic k2;
        logic k3;
        logic thy;
        logic ilim;
        logic [DATA_W-1:0] rdata;
    } ctrl_s;
    ctrl_s q;
    ctrl_s d;

    sec_timer_if hot_t ();
    sec_timer_if fin_t ();

    logic moving;
    logic cool;
    logic hot_out;
    logic fin_out;
    logic in_rescue;
    logic in_stop;

    assign moving = run_a ^ run_b;
    assign cool = stack_temp <= q.temp_lim;
    assign hot_out = !cool && hot_t.remaining == '0;
    assign fin_out = fin_t.remaining == '0;
    assign in_rescue = q.st == ST_RESCUE;
    assign in_stop = q.st == ST_STOP;

    // ==========================================================
    // Seconds timers
    // The hot slot restarts only once the stack is back at or below the start limit.
    assign hot_t.tick = q.tick;
    assign hot_t.load = cool; // [RULE9]
    assign hot_t.run = !cool;
    assign hot_t.preset = q.hot_slot;
    assign fin_t.tick = q.tick;
    assign fin_t.load = !in_rescue || q.k3; // [RULE13]
    assign fin_t.run = in_rescue && !q.k3;
    assign fin_t.preset = {4'h0, q.fin_time};

    sec_countdown hot_timer (
        .clk(clk),
        .reset_n(reset_n),
        .t(hot_t.tmr)
    );

    sec_countdown fin_timer (
        .clk(clk),
        .reset_n(reset_n),
        .t(fin_t.tmr)
    );

    // ==========================================================
    // Next state
    always_comb
    begin
        d = q;
        d.rdata = '0;
        d.tick = 1'b0;
        if (q.sec_cnt >= SEC_CYCLES_P - 24'h000001)
        begin
            d.sec_cnt = '0;
            d.tick = 1'b1;
        end
        else
        begin
            d.sec_cnt = q.sec_cnt + 24'h000001;
        end

        if (wr)
        begin
            unique case (addr)
                A_MODE:
                begin
                    if (wdata[1:0] <= MODE_HEAVY) // [RULE1]
                    begin
                        d.mode = wdata[1:0];
                    end
                end
                A_LOAD_THR: d.load_thr = wdata[6:0];
                A_TEMP_LIM: d.temp_lim = wdata[7:0];
                A_HOT_SLOT: d.hot_slot = wdata[9:0];
                A_CUR_LIM: d.cur_lim = wdata[8:0];
                A_LEV1: d.lev1 = wdata[6:0];
                A_LEV2: d.lev2 = wdata[6:0];
                A_STEP1: d.step1 = wdata[7:0];
                A_STEP2: d.step2 = wdata[7:0];
                A_STEP3: d.step3 = wdata[7:0];
                A_FIN_TIME: d.fin_time = wdata[5:0];
                A_STATUS:
                begin
                    if (wdata[ST_FINTRIP])
                    begin
                        d.fin_trip = 1'b0;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // The heavy-load sequencer only runs in mode 2; other modes park it in idle.
        unique case (q.st)
            ST_IDLE:
            begin
                if (q.mode == MODE_HEAVY && moving)
                begin
                    if (load_pct >= q.load_thr && cool) // [RULE6] [RULE8]
                    begin
                        d.st = ST_RESCUE;
                    end
                    else
                    begin
                        d.st = ST_CONV;
                    end
                end
            end
            ST_CONV:
            begin
                if (q.mode != MODE_HEAVY || !moving)
                begin
                    d.st = ST_IDLE;
                end
                else if (load_pct >= q.load_thr && cool) // [RULE6] [RULE8]
                begin
                    d.st = ST_RESCUE;
                end
            end
            ST_RESCUE:
            begin
                if (q.mode != MODE_HEAVY)
                begin
                    d.st = ST_IDLE;
                end
                else if (!moving || hot_out || fin_out) // [RULE9] [RULE13]
                begin
                    d.st = ST_STOP;
                end
            end
            ST_STOP:
            begin
                if (q.mode != MODE_HEAVY || speed_zero)
                begin
                    d.st = ST_IDLE;
                end
            end
            default: d.st = ST_IDLE;
        endcase

        // Trip on the final step timer; set wins over a software clear.
        if (in_rescue && moving && fin_out)
        begin
            d.fin_trip = 1'b1; // [RULE13]
        end

        // Thyristors bridge the contactor make on entering rescue and its break on entering stop, then hand over.
        if (d.st != q.st && (d.st == ST_RESCUE || d.st == ST_STOP))
        begin
            d.assist = ASSIST_CYCLES_P; // [RULE7]
        end
        else if (q.assist != '0)
        begin
            d.assist = q.assist - 20'h00001;
        end

        d.raise = 1'b0;
        d.lower = 1'b0;
        d.b1 = 1'b0;
        d.b2 = 1'b0;
        d.thy = 1'b0;
        d.ilim = 1'b0;
        unique case (d.st)
            ST_CONV:
            begin
                d.thy = 1'b1;
                d.b1 = 1'b1;
                d.b2 = 1'b1;
            end
            ST_RESCUE:
            begin
                d.raise = run_a && !run_b; // [RULE2]
                d.lower = run_b && !run_a; // [RULE3]
                d.thy = d.assist != '0; // [RULE7]
                d.b1 = 1'b1; // [RULE4]
                d.b2 = 1'b1;
                d.ilim = motor_current_pct > q.cur_lim; // [RULE10]
            end
            ST_STOP:
            begin
                d.thy = d.assist != '0;
                d.b1 = load_pct < q.lev1; // [RULE11]
                d.b2 = load_pct < q.lev2; // [RULE11]
            end
            default:
            begin
                if (q.mode == MODE_LOSS && full_conduction)
                begin
                    d.raise = run_a && !run_b; // [RULE5]
                    d.lower = run_b && !run_a; // [RULE5]
                end
            end
        endcase

        // Rotor steps latch once pulled in and drop when rescue ends.
        if (d.st == ST_RESCUE)
        begin
            d.k1 = q.k1 || speed_pct >= q.step1; // [RULE12]
            d.k2 = q.k2 || speed_pct >= q.step2; // [RULE12]
            d.k3 = q.k3 || speed_pct >= q.step3; // [RULE12]
        end
        else
        begin
            d.k1 = 1'b0;
            d.k2 = 1'b0;
            d.k3 = 1'b0;
        end

        if (q.mode == MODE_OFF)
        begin
            d.raise = 1'b0; // [RULE16]
            d.lower = 1'b0;
        end

        if (rd)
        begin
            unique case (addr)
                A_MODE: d.rdata = {14'h0000, q.mode};
                A_LOAD_THR: d.rdata = {9'h000, q.load_thr};
                A_TEMP_LIM: d.rdata = {8'h00, q.temp_lim};
                A_HOT_SLOT: d.rdata = {6'h00, q.hot_slot};
                A_CUR_LIM: d.rdata = {7'h00, q.cur_lim};
                A_LEV1: d.rdata = {9'h000, q.lev1};
                A_LEV2: d.rdata = {9'h000, q.lev2};
                A_STEP1: d.rdata = {8'h00, q.step1};
                A_STEP2: d.rdata = {8'h00, q.step2};
                A_STEP3: d.rdata = {8'h00, q.step3};
                A_FIN_TIME: d.rdata = {10'h000, q.fin_time};
                A_STATUS: d.rdata = {1'b0, q.ilim, q.thy, q.k3, q.k2, q.k1, q.b2,
                    q.b1, q.lower, q.raise, q.fin_trip, hot_out, q.st};
                A_REM_HOT: d.rdata = {6'h00, hot_t.remaining}; // [RULE14]
                A_REM_FIN: d.rdata = {6'h00, fin_t.remaining}; // [RULE15]
                default: d.rdata = '0;
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q <= '0;
            q.st <= ST_IDLE;
            q.load_thr <= RST_LOAD_THR;
            q.temp_lim <= RST_TEMP_LIM;
            q.hot_slot <= RST_HOT_SLOT;
            q.cur_lim <= RST_CUR_LIM;
            q.lev1 <= RST_LEV1;
            q.lev2 <= RST_LEV2;
            q.step1 <= RST_STEP1;
            q.step2 <= RST_STEP2;
            q.step3 <= RST_STEP3;
            q.fin_time <= RST_FIN_TIME;
        end
        else
        begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign raise_bypass_contactor = q.raise;
    assign lower_bypass_contactor = q.lower;
    assign brake1_release = q.b1;
    assign brake2_release = q.b2;
    assign first_rotor_step_contactor = q.k1;
    assign second_rotor_step_contactor = q.k2;
    assign final_rotor_step_contactor = q.k3;
    assign thyristor_enable = q.thy;
    assign current_limit_active = q.ilim;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_enter_rescue;
        !in_rescue ##1 in_rescue;
    endsequence

    sequence s_enter_stop;
        in_rescue ##1 in_stop;
    endsequence

    property p_mode_legal;
        q.mode != 2'h3;
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("illegal by-pass mode"); // [RULE1]

    property p_exclusive;
        !(raise_bypass_contactor && lower_bypass_contactor);
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("both contactors closed"); // [RULE16]

    property p_mode0_off;
        q.mode == MODE_OFF |=> !raise_bypass_contactor && !lower_bypass_contactor;
    endproperty
    a_mode0_off: assert property (p_mode0_off) else $error("contactor in mode 0"); // [RULE16]

    property p_loss_bypass;
        q.mode == MODE_LOSS && q.st == ST_IDLE && full_conduction && run_a && !run_b
            |=> raise_bypass_contactor;
    endproperty
    a_loss_bypass: assert property (p_loss_bypass) else $error("mode 1 no short"); // [RULE5]

    property p_raise_dir;
        $rose(raise_bypass_contactor) |-> $past(run_a) && !$past(run_b);
    endproperty
    a_raise_dir: assert property (p_raise_dir) else $error("raise without run_a"); // [RULE2]

    property p_lower_dir;
        $rose(lower_bypass_contactor) |-> $past(run_b) && !$past(run_a);
    endproperty
    a_lower_dir: assert property (p_lower_dir) else $error("lower without run_b"); // [RULE3]

    property p_start_cool;
        s_enter_rescue |-> $past(stack_temp, 1) <= $past(q.temp_lim, 1);
    endproperty
    a_start_cool: assert property (p_start_cool) else $error("rescue on hot stack"); // [RULE8]

    property p_enter_load;
        q.st == ST_CONV && q.mode == MODE_HEAVY && moving && cool && load_pct >= q.load_thr
            |=> in_rescue;
    endproperty
    a_enter_load: assert property (p_enter_load) else $error("no rescue at load"); // [RULE6]

    property p_assist;
        s_enter_rescue |-> thyristor_enable;
    endproperty
    a_assist: assert property (p_assist) else $error("no thyristor assist"); // [RULE7]

    property p_hot_end;
        in_rescue && q.mode == MODE_HEAVY && hot_out |=> in_stop;
    endproperty
    a_hot_end: assert property (p_hot_end) else $error("hot slot ignored"); // [RULE9]

    property p_cur_lim;
        current_limit_active |-> in_rescue && $past(motor_current_pct) > $past(q.cur_lim);
    endproperty
    a_cur_lim: assert property (p_cur_lim) else $error("bad current limit flag"); // [RULE10]

    property p_brakes;
        s_enter_stop |-> brake1_release == ($past(load_pct) < $past(q.lev1))
            && brake2_release == ($past(load_pct) < $past(q.lev2));
    endproperty
    a_brakes: assert property (p_brakes) else $error("extra brakes wrong"); // [RULE11]

    property p_steps;
        final_rotor_step_contactor |-> in_rescue
            && ($past(q.k3) || $past(speed_pct) >= $past(q.step3));
    endproperty
    a_steps: assert property (p_steps) else $error("rotor step outside rescue"); // [RULE12]

    property p_fin_trip;
        in_rescue && moving && q.mode == MODE_HEAVY && fin_out |=> in_stop && q.fin_trip;
    endproperty
    a_fin_trip: assert property (p_fin_trip) else $error("final step time ignored"); // [RULE13]
endmodule
`default_nettype wire

/* logic/bypass_pkg.sv */
// Constants, register map and state codes of the hoist by-pass contactor supervisor.
// Functional notes
// RULE1 - The by-pass mode is 0 for off, 1 for loss-saving full-voltage by-pass, 2 for heavy hoist by-pass.
// RULE2 - Output one closes the raise by-pass contactor for hoisting up or travel in direction A.
// RULE3 - Output two closes the lower by-pass contactor for lowering or travel in direction B.
// RULE4 - Outputs three and four release the two extra mechanical brakes used after heavy lowering.
// RULE5 - In mode 1 a fully conducting bridge is shorted by the contactor of the running direction.
// RULE6 - In mode 2 the drive leaves speed control for rescue by-pass once load reaches the threshold.
// RULE7 - In rescue by-pass the thyristors only carry the contactor switching moments.
// RULE8 - Rescue by-pass is entered only while the stack temperature is not above the start limit.
// RULE9 - Above the start limit rescue runs only for the hot time slot, then needs a cool stack again.
// RULE10 - Rescue by-pass limits motor current to the by-pass current limit.
// RULE11 - Stopping from rescue sets one extra brake from the first level and two from the second.
// RULE12 - Rescue by-pass pulls in the three rotor step contactors at their speed levels.
// RULE13 - High-load running before the final rotor step is bounded by the final step time.
// RULE14 - The remaining hot operating time is readable in seconds.
// RULE15 - The remaining time before the final rotor step must close is readable in seconds.
// RULE16 - Raise and lower contactors never close together and all by-pass outputs stay off in mode 0.
`default_nettype none
package bypass_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int SEC_S = 1;
    localparam int SEC_CYCLES = CLK_HZ * SEC_S;
    localparam int ASSIST_MS = 100;
    localparam int ASSIST_CYCLES = (CLK_HZ / 1000) * ASSIST_MS;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int SEC_W = 10;
    localparam logic [3:0] A_MODE = 4'h0;
    localparam logic [3:0] A_LOAD_THR = 4'h1;
    localparam logic [3:0] A_TEMP_LIM = 4'h2;
    localparam logic [3:0] A_HOT_SLOT = 4'h3;
    localparam logic [3:0] A_CUR_LIM = 4'h4;
    localparam logic [3:0] A_LEV1 = 4'h5;
    localparam logic [3:0] A_LEV2 = 4'h6;
    localparam logic [3:0] A_STEP1 = 4'h7;
    localparam logic [3:0] A_STEP2 = 4'h8;
    localparam logic [3:0] A_STEP3 = 4'h9;
    localparam logic [3:0] A_FIN_TIME = 4'ha;
    localparam logic [3:0] A_STATUS = 4'hb;
    localparam logic [3:0] A_REM_HOT = 4'hc;
    localparam logic [3:0] A_REM_FIN = 4'hd;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_LOSS = 2'h1;
    localparam logic [1:0] MODE_HEAVY = 2'h2;
    localparam logic [6:0] RST_LOAD_THR = 7'h37;
    localparam logic [7:0] RST_TEMP_LIM = 8'h28;
    localparam logic [9:0] RST_HOT_SLOT = 10'h384;
    localparam logic [8:0] RST_CUR_LIM = 9'h14a;
    localparam logic [6:0] RST_LEV1 = 7'h37;
    localparam logic [6:0] RST_LEV2 = 7'h50;
    localparam logic [7:0] RST_STEP1 = 8'hf6;
    localparam logic [7:0] RST_STEP2 = 8'h1e;
    localparam logic [7:0] RST_STEP3 = 8'h41;
    localparam logic [5:0] RST_FIN_TIME = 6'h14;
    localparam int ST_FINTRIP = 5;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CONV = 4'h2,
        ST_RESCUE = 4'h4,
        ST_STOP = 4'h8
    } bp_state_e;
endpackage
`default_nettype wire

/* logic/sec_timer_if.sv */
// Interface between the supervisor and its seconds countdown timers.
`timescale 1ns/1ps
`default_nettype none
interface sec_timer_if;
    logic tick;
    logic load;
    logic run;
    logic [9:0] preset;
    logic [9:0] remaining;
    modport ctl (output tick, output load, output run, output preset, input remaining);
    modport tmr (input tick, input load, input run, input preset, output remaining);
endinterface
`default_nettype wire

/* logic/sec_countdown.sv */
// Seconds countdown timer, reloaded while idle and counting down on the seconds tick.
`timescale 1ns/1ps
`default_nettype none
module sec_countdown (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control from the supervisor
    sec_timer_if.tmr t
);
    import bypass_pkg::*;
    typedef struct packed {
        logic [SEC_W-1:0] rem;
    } tmr_s;
    tmr_s q;
    tmr_s d;

    always_comb
    begin
        d = q;
        if (t.load)
        begin
            d.rem = t.preset;
        end
        else if (t.run && t.tick && q.rem != '0)
        begin
            d.rem = q.rem - 10'h001;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign t.remaining = q.rem;
endmodule
`default_nettype wire

/* verification/hoist_plant_model.sv */
// Behavioural contactors and load cell on the far side of the by-pass supervisor.
`timescale 1ns/1ps
`default_nettype none
module hoist_plant_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Contactor commands
    input wire logic raise_on,
    input wire logic lower_on,
    // Bench settings
    input wire logic [6:0] load_set,
    input wire logic signed [7:0] speed_cap,
    // Measurements
    output logic [6:0] load_pct,
    output logic signed [7:0] speed_pct,
    output logic speed_zero
);
    // Speed climbs one percent a cycle while a contactor feeds the motor and
    // coasts down otherwise, so rotor steps and stops take realistic time.
    assign load_pct = load_set;
    assign speed_zero = (speed_pct == 8'sh00);
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            speed_pct <= 8'sh00;
        else if ((raise_on || lower_on) && speed_pct < speed_cap)
            speed_pct <= speed_pct + 8'sh01;
        else if (!(raise_on || lower_on) && speed_pct > 8'sh00)
            speed_pct <= speed_pct - 8'sh01;
    end
endmodule
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench of the hoist by-pass contactor supervisor.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bypass_pkg::*;
    logic clk, reset_n, wr, rd, run_a, run_b, full_conduction;
    logic [3:0] addr;
    logic [15:0] wdata, rdata;
    logic [6:0] load_set, load_pct;
    logic [7:0] stack_temp;
    logic [8:0] motor_current_pct;
    logic signed [7:0] speed_cap, speed_pct;
    logic speed_zero, raise_c, lower_c, brake1, brake2, step1, step2, step3, thy, ilim;
    int err_count, checks_done;

    // ========================================
    // Design and far side
    hoist_bypass_contactor_ctrl #(.SEC_CYCLES_P(24'h00000a), .ASSIST_CYCLES_P(20'h00004)) dut_u (
        .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .run_a(run_a), .run_b(run_b), .full_conduction(full_conduction),
        .speed_zero(speed_zero), .load_pct(load_pct), .stack_temp(stack_temp),
        .motor_current_pct(motor_current_pct), .speed_pct(speed_pct),
        .raise_bypass_contactor(raise_c), .lower_bypass_contactor(lower_c),
        .brake1_release(brake1), .brake2_release(brake2),
        .first_rotor_step_contactor(step1), .second_rotor_step_contactor(step2),
        .final_rotor_step_contactor(step3), .thyristor_enable(thy),
        .current_limit_active(ilim));
    hoist_plant_model plant_u (
        .clk(clk), .reset_n(reset_n), .raise_on(raise_c), .lower_on(lower_c),
        .load_set(load_set), .speed_cap(speed_cap), .load_pct(load_pct),
        .speed_pct(speed_pct), .speed_zero(speed_zero));

    // ========================================
    // Shared tasks
    task automatic complete_run();
        if (err_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        d = rdata;
    endtask
    // Polls one status bit; running out of polls ends the run as a failure.
    task automatic wait_bit(input string n, input int b, input logic v);
        logic [15:0] s;
        int i;
        i = 0;
        rd_reg(A_STATUS, s);
        while (s[b] !== v && i < 300)
        begin
            rd_reg(A_STATUS, s);
            i++;
        end
        chk(n, {15'h0000, v}, {15'h0000, s[b]});
        if (s[b] !== v)
            complete_run();
    endtask

    // ========================================
    // Scenarios
    task automatic s_defaults();
        logic [15:0] d;
        logic [15:0] e [16];
        e = '{16'h0000, 16'h0037, 16'h0028, 16'h0384, 16'h014a, 16'h0037, 16'h0050, 16'h00f6,
              16'h001e, 16'h0041, 16'h0014, 16'h0001, 16'h0384, 16'h0014, 16'h0000, 16'h0000};
        @(posedge clk);
        run_a <= 1'h1;
        full_conduction <= 1'h1;
        tick(3);
        chk("raise", 1'h0, raise_c);
        chk("thyristor", 1'h0, thy);
        for (int i = 0; i < 16; i++)
        begin
            rd_reg(4'(i), d);
            chk($sformatf("register %0h", i), e[i], d);
        end
        wr_reg(A_MODE, 16'h0003);
        rd_reg(A_MODE, d);
        chk("mode", 16'h0000, d);
        wr_reg(A_STATUS, 16'h000e);
        rd_reg(A_STATUS, d);
        chk("status", 16'h0001, d);
    endtask
    task automatic s_mode1();
        wr_reg(A_MODE, 16'h0001);
        tick(2);
        chk("raise", 1'h1, raise_c);
        chk("lower", 1'h0, lower_c);
        @(posedge clk);
        run_a <= 1'h0;
        run_b <= 1'h1;
        tick(2);
        chk("raise", 1'h0, raise_c);
        chk("lower", 1'h1, lower_c);
        @(posedge clk);
        full_conduction <= 1'h0;
        tick(2);
        chk("lower", 1'h0, lower_c);
        run_b <= 1'h0;
    endtask
    task automatic s_rescue();
        load_set <= 7'h3c;
        stack_temp <= 8'h1e;
        wr_reg(A_MODE, 16'h0002);
        run_a <= 1'h1;
        tick(2);
        chk("raise", 1'h1, raise_c);
        chk("thyristor", 1'h1, thy);
        chk("brakes", 2'h3, {brake1, brake2});
        tick(5);
        chk("thyristor", 1'h0, thy);
        motor_current_pct <= 9'h154;
        tick(2);
        chk("current limit", 1'h1, ilim);
        motor_current_pct <= 9'h14a;
        tick(2);
        chk("current limit", 1'h0, ilim);
        wait_bit("final step", 12, 1'h1);
        chk("steps", 2'h3, {step1, step2});
        run_a <= 1'h0;
        tick(2);
        chk("raise", 1'h0, raise_c);
        chk("brakes", 2'h1, {brake1, brake2});
        chk("thyristor", 1'h1, thy);
        wait_bit("idle", 0, 1'h1);
    endtask
    task automatic s_hot();
        logic [15:0] d;
        load_set <= 7'h55;
        wr_reg(A_HOT_SLOT, 16'h0002);
        tick(2);
        rd_reg(A_REM_HOT, d);
        chk("hot remaining", 16'h0002, d);
        run_a <= 1'h1;
        wait_bit("rescue", 2, 1'h1);
        stack_temp <= 8'h29;
        wait_bit("hot expired", 4, 1'h1);
        tick(1);
        chk("brakes", 2'h0, {brake1, brake2});
        wait_bit("conventional", 1, 1'h1);
        tick(1);
        chk("raise", 1'h0, raise_c);
        stack_temp <= 8'h1e;
        wait_bit("rescue after cooling", 2, 1'h1);
        rd_reg(A_REM_HOT, d);
        chk("hot reload", 16'h0002, d);
        run_a <= 1'h0;
        wait_bit("idle", 0, 1'h1);
    endtask
    task automatic s_final();
        logic [15:0] d;
        wr_reg(A_FIN_TIME, 16'h0001);
        tick(2);
        rd_reg(A_REM_FIN, d);
        chk("final remaining", 16'h0001, d);
        speed_cap <= 8'sh32;
        run_a <= 1'h1;
        wait_bit("final trip", 5, 1'h1);
        chk("final step", 1'h0, step3);
        run_a <= 1'h0;
        wait_bit("idle", 0, 1'h1);
        wr_reg(A_STATUS, 16'h0020);
        rd_reg(A_STATUS, d);
        chk("status", 16'h0001, d);
    endtask

    // ========================================
    // Clock, reset, sequence and watchdog
    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        {reset_n, wr, rd, run_a, run_b, full_conduction} = 6'h00;
        addr = 4'h0;
        wdata = 16'h0000;
        load_set = 7'h00;
        stack_temp = 8'h00;
        motor_current_pct = 9'h000;
        speed_cap = 8'sh64;
        repeat (5) @(posedge clk);
        reset_n <= 1'h1;
        s_defaults();
        s_mode1();
        s_rescue();
        s_hot();
        s_final();
        complete_run();
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        chk("watchdog", 16'h0000, 16'h0001);
        complete_run();
    end
endmodule
`default_nettype wire
